/* shared/ubr_consts.svh */
// Purpose: Offsets, field positions, reset values and counts of the break and receive block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Included by bare name
`ifndef UBR_CONSTS_SVH
`define UBR_CONSTS_SVH

// Register offsets
`define UBR_OFF_CTRL 8'h00
`define UBR_OFF_STAT 8'h04
`define UBR_OFF_DATA 8'h08
`define UBR_OFF_BAUD 8'h0C

// Control register fields
`define UBR_CB_PORT_ON 0
`define UBR_CB_RX_ON 1
`define UBR_CB_NINE 2
`define UBR_CB_PAR_ON 3
`define UBR_CB_PAR_ODD 4
`define UBR_CB_STOP2 5
`define UBR_CB_BREAK 6
`define UBR_CB_IRQ_EN 7
`define UBR_CB_NINTH 8

// Status register fields
`define UBR_SB_AVAIL 0
`define UBR_SB_OVERRUN 1
`define UBR_SB_NOISE 2
`define UBR_SB_FRAME 3
`define UBR_SB_PARITY 4
`define UBR_SB_RX_IDLE 5
`define UBR_SB_TX_BRK 6

// Reset values
`define UBR_CTRL_RST 8'h00
`define UBR_BAUD_RST 16'h0000

// Oversampling: 16 ticks a bit, samples at ticks 7, 8 and 9
`define UBR_OS_LAST 4'hF
`define UBR_SMP_A 4'h7
`define UBR_SMP_B 4'h8
`define UBR_SMP_MID 4'h9

// Word lengths, break length, buffer depth
`define UBR_LAST_BIT8 4'h7
`define UBR_LAST_BIT9 4'h8
`define UBR_BRK_LAST 4'hD
`define UBR_DEPTH 2'h2

`endif

/* shared/ubr_pkg.sv */
// Purpose: Types of the break and receive block
// Assumes: Constants come from ubr_consts.svh
// Notes: APB request travels as one packed struct
`default_nettype none
package ubr_pkg;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ubr_apb_req_t;

   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } ubr_entry_t;

   typedef enum logic [4:0] {
      UBR_RX_IDLE = 5'b00001,
      UBR_RX_START = 5'b00010,
      UBR_RX_DATA = 5'b00100,
      UBR_RX_STOP = 5'b01000,
      UBR_RX_WAITHI = 5'b10000
   } ubr_rx_state_t;

   typedef enum logic [2:0] {
      UBR_TX_IDLE = 3'b001,
      UBR_TX_BRK = 3'b010,
      UBR_TX_STOP = 3'b100
   } ubr_tx_state_t;

endpackage : ubr_pkg
`default_nettype wire

/* logic/ubr_receiver.sv */
// Purpose: Break generation on the transmit line and the receive path of a serial port, less address detect and wake-up
// Assumes: APB slave, 100 MHz REF_CLK, serial input asynchronous to REF_CLK
// Notes: Normal transmit path, address detect and wake-up live elsewhere
//
// Functional notes
// R1: Break armed after control high over divisor+1 clocks
// R2: Break is start plus 13 zero bits, repeating
// R3: Break sends raise no transmit interrupt
// R4: Breaks repeat while set; then finish, stop bits
// R5: Eight or nine bit words; ninth bit readable
// R6: Sampling at 16x, shifting once per bit
// R7: Bit level by majority of three samples
// R8: LSB first shift register, hidden from software
// R9: Word moves to two-entry buffer after stop
// R10: Third word on full buffer sets overrun, lost
// R11: Data available while buffered; interrupt on transfer
// R12: Available clears by status read then data read
// R13: Overrun clears by status access then data read
// R14: Noise flag set with word, no own interrupt
// R15: Zero stop bit sets framing error, word kept
// R16: Parity error only when parity enabled
// R17: Idle low from start until stop read
// R18: Long break closes as zero word, framing error
// R19: After break, wait for high before start search
// R20: Framing and parity flags cleared by reset
// R21: Software reads error flags before data word
// R22: Enabled receiver starts searching for start bit
// R23: Disabling the port empties the buffer
// R24: Receiver checks exactly one stop bit
// R25: Start by falling edge; sample near bit centre
// R26: Parity over all bits, parity bit last
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ubr_consts.svh"

module ubr_receiver (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // APB slave
   input wire ubr_pkg::ubr_apb_req_t APB_REQ,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Serial pins
   input wire logic SERIAL_IN_PIN,
   output logic TX_PIN,
   // Receive event
   output logic RX_IRQ
);
   import ubr_pkg::*;

   // Bus decode; every access waits one cycle so all answers come from flops
   logic pready_q, pslverr_q, rx_irq_q, tx_pin_q;
   logic [31:0] prdata_q;
   wire logic acc = APB_REQ.psel & APB_REQ.penable;
   wire logic first = acc & ~pready_q;
   wire logic done = acc & pready_q;
   wire logic sel_ctrl = APB_REQ.paddr == `UBR_OFF_CTRL;
   wire logic sel_stat = APB_REQ.paddr == `UBR_OFF_STAT;
   wire logic sel_data = APB_REQ.paddr == `UBR_OFF_DATA;
   wire logic sel_baud = APB_REQ.paddr == `UBR_OFF_BAUD;
   wire logic mapped = sel_ctrl | sel_stat | sel_data | sel_baud;
   wire logic wr_ctrl = done & APB_REQ.pwrite & sel_ctrl;
   wire logic wr_baud = done & APB_REQ.pwrite & sel_baud;
   wire logic rd_data = done & ~APB_REQ.pwrite & sel_data;

   // Software controls
   logic port_on_q, receiver_on_q, nine_bit_sel_q, parity_on_q, parity_type_sel_q;
   logic stop2_q, send_break_ctl_q, rx_irq_enable_q, status_seen_q;
   logic [15:0] baud_divisor_q;

   // Receive buffer and flags
   ubr_entry_t fifo_q [2];
   logic [1:0] cnt_q;
   logic overrun_flag_q, noise_flag_q, frame_err_flag_q, parity_err_flag_q;

   // Receiver state
   ubr_rx_state_t rx_q, rx_d;
   logic rx_meta_q, rx_sync_q, rx_prev_q;
   logic [3:0] sub_q, bits_q;
   logic [8:0] rx_shift_reg_q;
   logic [1:0] win_q;
   logic noise_acc_q;

   // Break transmitter state
   ubr_tx_state_t tx_q, tx_d;
   logic [3:0] tx_sub_q, tx_cnt_q;
   logic [16:0] hold_q;
   logic [15:0] div_q;

   // Oversampling tick, one per divisor+1 clocks
   wire logic os_tick = div_q == baud_divisor_q; // [R6]

   // Receive timing and majority vote
   wire logic rx_run = port_on_q & receiver_on_q;
   wire logic fall = rx_prev_q & ~rx_sync_q; // [R25]
   wire logic mid = os_tick & (sub_q == `UBR_SMP_MID); // [R25]
   wire logic smp = os_tick & ((sub_q == `UBR_SMP_A) | (sub_q == `UBR_SMP_B));
   wire logic vote = (win_q[1] & win_q[0]) | (win_q[1] & rx_sync_q)
      | (win_q[0] & rx_sync_q); // [R7]
   wire logic disagree = ~((win_q[1] == win_q[0]) & (win_q[0] == rx_sync_q));
   wire logic [3:0] last_bit = nine_bit_sel_q ? `UBR_LAST_BIT9 : `UBR_LAST_BIT8; // [R5]
   wire logic [8:0] word9 = nine_bit_sel_q ? rx_shift_reg_q : {1'b0, rx_shift_reg_q[8:1]};
   wire logic rx_push = (rx_q == UBR_RX_STOP) & mid; // [R9] [R24]
   wire logic frame_bad = ~vote; // [R15] [R18]
   wire logic par_bad = parity_on_q & ((^rx_shift_reg_q) != parity_type_sel_q); // [R16] [R26]
   wire logic noise_now = noise_acc_q | disagree;

   // Buffer control
   wire logic seq_clr = rd_data & status_seen_q; // [R12] [R13]
   wire logic pop = seq_clr & (cnt_q != 2'h0);
   wire logic full = cnt_q == `UBR_DEPTH;
   wire logic push_ok = rx_push & (~full | pop); // [R9]
   wire logic overrun_evt = rx_push & full & ~pop; // [R10]
   wire logic [1:0] wr_idx = pop ? (cnt_q - 2'h1) : cnt_q;
   wire logic [1:0] cnt_d = cnt_q + {1'b0, push_ok} - {1'b0, pop};
   wire ubr_entry_t new_entry = '{ninth: word9[8], data: word9[7:0]};
   wire logic rx_idle = (rx_q == UBR_RX_IDLE) | (rx_q == UBR_RX_WAITHI); // [R17]

   // Break timing
   wire logic armed = send_break_ctl_q
      & (hold_q > ({1'b0, baud_divisor_q} + 17'h00001)); // [R1]
   wire logic tx_end = os_tick & (tx_sub_q == `UBR_OS_LAST);
   wire logic [3:0] stop_last = stop2_q ? 4'h1 : 4'h0; // [R4]

   // Read data
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0000_0000;
      if (sel_ctrl) begin
         rd_word[`UBR_CB_PORT_ON] = port_on_q;
         rd_word[`UBR_CB_RX_ON] = receiver_on_q;
         rd_word[`UBR_CB_NINE] = nine_bit_sel_q;
         rd_word[`UBR_CB_PAR_ON] = parity_on_q;
         rd_word[`UBR_CB_PAR_ODD] = parity_type_sel_q;
         rd_word[`UBR_CB_STOP2] = stop2_q;
         rd_word[`UBR_CB_BREAK] = send_break_ctl_q;
         rd_word[`UBR_CB_IRQ_EN] = rx_irq_enable_q;
         rd_word[`UBR_CB_NINTH] = fifo_q[0].ninth; // [R5]
      end
      if (sel_stat) begin
         rd_word[`UBR_SB_AVAIL] = cnt_q != 2'h0; // [R11]
         rd_word[`UBR_SB_OVERRUN] = overrun_flag_q;
         rd_word[`UBR_SB_NOISE] = noise_flag_q;
         rd_word[`UBR_SB_FRAME] = frame_err_flag_q;
         rd_word[`UBR_SB_PARITY] = parity_err_flag_q;
         rd_word[`UBR_SB_RX_IDLE] = rx_idle | ~rx_run;
         rd_word[`UBR_SB_TX_BRK] = tx_q != UBR_TX_IDLE;
      end
      if (sel_data) begin
         rd_word[7:0] = fifo_q[0].data; // Shift register itself is never mapped [R8]
      end
      if (sel_baud) begin
         rd_word[15:0] = baud_divisor_q;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= first;
         pslverr_q <= first & ~mapped;
         prdata_q <= (first & ~APB_REQ.pwrite) ? rd_word : 32'h0000_0000;
      end
   end

   // Control register; disabling the port also drops break and receive enable
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         {rx_irq_enable_q, send_break_ctl_q, stop2_q, parity_type_sel_q,
            parity_on_q, nine_bit_sel_q, receiver_on_q, port_on_q} <= `UBR_CTRL_RST;
         baud_divisor_q <= `UBR_BAUD_RST;
      end else begin
         if (wr_ctrl) begin
            {rx_irq_enable_q, send_break_ctl_q, stop2_q, parity_type_sel_q,
               parity_on_q, nine_bit_sel_q, receiver_on_q, port_on_q}
               <= APB_REQ.pwdata[7:0]; // [R4]
         end else if (~port_on_q) begin
            receiver_on_q <= 1'b0;
            send_break_ctl_q <= 1'b0;
         end
         if (wr_baud) begin
            baud_divisor_q <= APB_REQ.pwdata[15:0];
         end
      end
   end

   // Status access arms the clearing read; the data read disarms it
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         status_seen_q <= 1'b0;
      end else if (done & sel_stat) begin
         status_seen_q <= 1'b1; // [R12]
      end else if (rd_data) begin
         status_seen_q <= 1'b0;
      end
   end

   // Two-entry buffer, one generate slot per entry
   for (genvar i = 0; i < 2; i++) begin : g_entry
      always_ff @(posedge REF_CLK or posedge RESET) begin
         if (RESET) begin
            fifo_q[i] <= '0;
         end else if (push_ok & (wr_idx == 2'(i))) begin
            fifo_q[i] <= new_entry; // [R9]
         end else if (pop & (i == 0)) begin
            fifo_q[i] <= fifo_q[1];
         end
      end
   end

   // Flags: a set in the clearing cycle wins
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         cnt_q <= 2'h0;
         overrun_flag_q <= 1'b0;
         noise_flag_q <= 1'b0;
         frame_err_flag_q <= 1'b0; // [R20]
         parity_err_flag_q <= 1'b0; // [R20]
      end else if (~port_on_q) begin
         cnt_q <= 2'h0; // [R23]
         overrun_flag_q <= 1'b0;
         noise_flag_q <= 1'b0;
         frame_err_flag_q <= 1'b0;
         parity_err_flag_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         overrun_flag_q <= overrun_evt | (overrun_flag_q & ~seq_clr); // [R10] [R13]
         noise_flag_q <= (push_ok & noise_now) | (noise_flag_q & ~seq_clr); // [R14]
         frame_err_flag_q <= (push_ok & frame_bad) | (frame_err_flag_q & ~seq_clr); // [R15]
         parity_err_flag_q <= (push_ok & par_bad) | (parity_err_flag_q & ~seq_clr); // [R16]
      end
   end

   // Receive event pulse; noise alone never adds one
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         rx_irq_q <= 1'b0;
      end else begin
         rx_irq_q <= rx_irq_enable_q & port_on_q & (push_ok | overrun_evt); // [R11] [R10] [R14]
      end
   end

   // Divider
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= os_tick ? 16'h0000 : div_q + 16'h0001;
      end
   end

   // Input synchroniser; first stage feeds only the second
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end else begin
         rx_meta_q <= SERIAL_IN_PIN;
         rx_sync_q <= rx_meta_q;
         rx_prev_q <= rx_sync_q;
      end
   end

   // Receive sequence
   always_comb begin
      rx_d = rx_q;
      case (rx_q)
         UBR_RX_IDLE: if (fall) rx_d = UBR_RX_START; // [R22] [R25]
         UBR_RX_START: if (mid) rx_d = vote ? UBR_RX_IDLE : UBR_RX_DATA;
         UBR_RX_DATA: if (mid & (bits_q == last_bit)) rx_d = UBR_RX_STOP; // [R18]
         UBR_RX_STOP: if (mid) rx_d = vote ? UBR_RX_IDLE : UBR_RX_WAITHI; // [R19]
         UBR_RX_WAITHI: if (mid & vote) rx_d = UBR_RX_IDLE; // [R19]
         default: rx_d = UBR_RX_IDLE;
      endcase
      if (~rx_run) begin
         rx_d = UBR_RX_IDLE;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         rx_q <= UBR_RX_IDLE;
         sub_q <= 4'h0;
         bits_q <= 4'h0;
         win_q <= 2'h3;
         noise_acc_q <= 1'b0;
         rx_shift_reg_q <= 9'h000;
      end else begin
         rx_q <= rx_d;
         if (rx_q == UBR_RX_IDLE) begin
            sub_q <= 4'h0;
            bits_q <= 4'h0;
            noise_acc_q <= 1'b0;
            rx_shift_reg_q <= 9'h000;
         end else if (os_tick) begin
            sub_q <= sub_q + 4'h1; // [R6]
         end
         if (smp) begin
            win_q <= {win_q[0], rx_sync_q}; // [R7]
         end
         if (mid & (rx_q != UBR_RX_IDLE) & (rx_q != UBR_RX_WAITHI)) begin
            noise_acc_q <= noise_acc_q | disagree; // [R14]
         end
         if (mid & (rx_q == UBR_RX_DATA)) begin
            rx_shift_reg_q <= {vote, rx_shift_reg_q[8:1]}; // [R8] [R6]
            bits_q <= bits_q + 4'h1;
         end
      end
   end

   // Break transmitter
   always_comb begin
      tx_d = tx_q;
      case (tx_q)
         UBR_TX_IDLE: if (armed) tx_d = UBR_TX_BRK; // [R1]
         UBR_TX_BRK:
            if (tx_end & (tx_cnt_q == `UBR_BRK_LAST) & ~send_break_ctl_q) begin
               tx_d = UBR_TX_STOP; // [R4]
            end
         UBR_TX_STOP: if (tx_end & (tx_cnt_q == stop_last)) tx_d = UBR_TX_IDLE;
         default: tx_d = UBR_TX_IDLE;
      endcase
      if (~port_on_q) begin
         tx_d = UBR_TX_IDLE;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         tx_q <= UBR_TX_IDLE;
         tx_sub_q <= 4'h0;
         tx_cnt_q <= 4'h0;
         hold_q <= 17'h00000;
         tx_pin_q <= 1'b1;
      end else begin
         tx_q <= tx_d;
         tx_pin_q <= tx_d != UBR_TX_BRK; // No transmit event is raised here [R3]
         if (~send_break_ctl_q) begin
            hold_q <= 17'h00000;
         end else if (~armed) begin
            hold_q <= hold_q + 17'h00001; // [R1]
         end
         if (tx_q != tx_d) begin
            tx_sub_q <= 4'h0;
            tx_cnt_q <= 4'h0;
         end else if (os_tick & (tx_q != UBR_TX_IDLE)) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_end) begin
               tx_cnt_q <= ((tx_q == UBR_TX_BRK) & (tx_cnt_q == `UBR_BRK_LAST))
                  ? 4'h1 : tx_cnt_q + 4'h1; // [R2]
            end
         end
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign TX_PIN = tx_pin_q;
   assign RX_IRQ = rx_irq_q;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   sequence stop_seen_s;
      (rx_q == UBR_RX_STOP) & mid;
   endsequence

   break_arm_a: assert property ((tx_q == UBR_TX_IDLE) & (tx_d == UBR_TX_BRK) |-> armed) // [R1]
      else $error("break started without hold time");
   break_low_a: assert property ($rose(tx_q == UBR_TX_BRK) |-> !TX_PIN [*8]) // [R2]
      else $error("break line not low");
   irq_push_a: assert property (push_ok & rx_irq_enable_q & port_on_q |=> RX_IRQ) // [R11]
      else $error("no receive event on transfer");
   overrun_keep_a: assert property (overrun_evt & port_on_q
      |=> overrun_flag_q && cnt_q == `UBR_DEPTH && $stable(fifo_q[0])) // [R10]
      else $error("overrun handling wrong");
   avail_hold_a: assert property ((cnt_q != 2'h0) & ~seq_clr & port_on_q
      |=> cnt_q != 2'h0) // [R12]
      else $error("data available dropped without read sequence");
   idle_low_a: assert property ((rx_q == UBR_RX_START) & mid & ~vote & rx_run
      |=> !rx_idle until_with (rx_q == UBR_RX_STOP)) // [R17]
      else $error("idle high during frame");
   frame_set_a: assert property (stop_seen_s ##0 (frame_bad & push_ok & port_on_q)
      |=> frame_err_flag_q) // [R15]
      else $error("framing error not recorded");
   parity_off_a: assert property (~parity_on_q & push_ok & ~parity_err_flag_q & port_on_q
      |=> ~parity_err_flag_q) // [R16]
      else $error("parity error with parity off");
   break_wait_a: assert property (stop_seen_s ##0 (~vote & rx_run) |=> rx_q == UBR_RX_WAITHI) // [R19]
      else $error("start search resumed after break");
   off_empty_a: assert property (~port_on_q |=> cnt_q == 2'h0) // [R23]
      else $error("buffer kept while port off");

endmodule : ubr_receiver
`default_nettype wire

/* tb/ubr_remote_tx.sv */
// Purpose: Remote serial transmitter facing the receive pin of the block
// Assumes: Frame bits come LSB first, start bit at index 0
// Notes: Line idles high like a pulled-up wire; a glitch may hit one bit
`timescale 1ns/1ns
`default_nettype none

module ubr_remote_tx (
   // Clock and frame request
   input wire logic clk,
   input wire logic go,
   input wire logic [31:0] bits,
   input wire logic [5:0] nbits,
   input wire logic [15:0] bit_clks,
   input wire logic [5:0] glitch_bit,
   // Line side
   output logic line,
   output logic busy
);
   int b;
   int c;
   logic g;

   initial begin
      line = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            busy <= 1'b1;
            // Start, data, parity and stop leave in order
            for (b = 0; b < nbits; b++) begin
               for (c = 0; c < bit_clks; c++) begin
                  // One tick wide flip near mid bit, so it hits one vote
                  g = (b == glitch_bit) && (c >= bit_clks / 2) && (c < bit_clks / 2 + 2);
                  line <= bits[b] ^ g;
                  @(posedge clk);
               end
            end
            line <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
endmodule : ubr_remote_tx
`default_nettype wire

/* tb/tb_uart_break_and_receiver.sv */
// Purpose: Self-checking bench of the break and receive block
// Assumes: Divisor 1, so one bit lasts 32 clocks
// Notes: Words come from an LFSR with a fixed seed
`timescale 1ns/1ns
`default_nettype none
`include "ubr_consts.svh"

module tb_uart_break_and_receiver;
   import ubr_pkg::*;
   localparam int BC = 32;
   localparam logic [7:0] CT = `UBR_OFF_CTRL;
   localparam logic [7:0] ST = `UBR_OFF_STAT;
   localparam logic [7:0] DT = `UBR_OFF_DATA;
   logic clk = 1'b0;
   logic rst = 1'b1;
   ubr_apb_req_t req = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ser;
   logic tx;
   logic irq;
   logic busy;
   logic go = 1'b0;
   logic perr;
   logic [31:0] fbits = '1;
   logic [5:0] fn = 6'h02;
   logic [5:0] gbit = 6'h3F;
   logic [31:0] rdv;
   logic [31:0] w;
   logic [31:0] rs = 32'h0000289F;
   logic [7:0] wq [3];
   int bad_count = 0;
   int n_checks = 0;
   int irq_cnt = 0;
   int lowc = 0;
   int k;
   int t;
   int g;

   ubr_receiver i_ubr_receiver (.REF_CLK(clk), .RESET(rst), .APB_REQ(req), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .SERIAL_IN_PIN(ser), .TX_PIN(tx), .RX_IRQ(irq));
   ubr_remote_tx i_ubr_remote_tx (.clk(clk), .go(go), .bits(fbits), .nbits(fn),
      .bit_clks(16'(BC)), .glitch_bit(gbit), .line(ser), .busy(busy));

   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (irq === 1'b1) irq_cnt++;
      if (tx === 1'b0) lowc++;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      while (pready !== 1'b1) @(posedge clk);
      rdv = prdata;
      perr = pslverr;
      req <= '0;
   endtask : apb

   // Status access, then data read, pops the head
   task automatic pop(input logic [31:0] exp);
      apb(1'b0, ST, 32'h0);
      apb(1'b0, DT, 32'h0);
      check(rdv, exp);
   endtask : pop

   task automatic send(input logic [31:0] d, input int n, input logic stp, input logic [5:0] gb);
      int i;
      logic [31:0] f;
      f = '1;
      f[0] = 1'b0;
      for (i = 0; i < n; i++) f[i + 1] = d[i];
      f[n + 1] = stp;
      @(posedge clk);
      fbits <= f;
      fn <= 6'(n + 2);
      gbit <= gb;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      // Busy rises on the edge that sees go, one edge after go is set, so wait for the rise first
      while (busy !== 1'b1) @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
      // Idle line so a receiver parked after a zero stop bit sees high again
      repeat (2 * BC) @(posedge clk);
   endtask : send

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      give_verdict();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      check(32'(tx), 32'h1);
      apb(1'b0, CT, 32'h0);
      check(rdv, 32'h0);
      apb(1'b0, ST, 32'h0);
      check(32'(rdv[4:0]), 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check(rdv, 32'h0);
      check(32'(perr), 32'h1);
      apb(1'b1, `UBR_OFF_BAUD, 32'h1);
      // Two stop bits for the transmitter must not matter here
      apb(1'b1, CT, 32'hA3);
      for (k = 0; k < 3; k++) begin
         rs = lfsr(rs);
         wq[k] = rs[7:0];
         send(rs, 8, 1'b1, 6'h3F);
      end
      apb(1'b0, ST, 32'h0);
      check(32'(rdv[5:0]), 32'h23);
      check(irq_cnt, 3);
      pop(32'(wq[0]));
      pop(32'(wq[1]));
      apb(1'b0, ST, 32'h0);
      check(32'(rdv[1:0]), 32'h0);
      apb(1'b1, CT, 32'h87);
      rs = lfsr(rs);
      send(rs, 9, 1'b1, 6'h3F);
      apb(1'b0, CT, 32'h0);
      check(32'(rdv[8]), 32'(rs[8]));
      pop({24'h0, rs[7:0]});
      for (t = 0; t < 2; t++) begin
         for (g = 0; g < 2; g++) begin
            apb(1'b1, CT, 32'h8B | (32'(t) << 4));
            rs = lfsr(rs);
            w = {24'h0, ^rs[6:0] ^ t[0] ^ ~g[0], rs[6:0]};
            send(w, 8, 1'b1, 6'h3F);
            apb(1'b0, ST, 32'h0);
            check(32'(rdv[4]), 32'(g == 0));
            apb(1'b0, DT, 32'h0);
            check(rdv, w);
         end
      end
      apb(1'b1, CT, 32'h83);
      rs = lfsr(rs);
      w = {24'h0, rs[7:0]};
      send(w, 8, 1'b0, 6'h3F);
      apb(1'b0, ST, 32'h0);
      check(32'(rdv[3]), 32'h1);
      apb(1'b0, DT, 32'h0);
      check(rdv, w);
      // Long break, then a normal word right behind it
      send(32'h0, 19, 1'b0, 6'h3F);
      rs = lfsr(rs);
      w = {24'h0, rs[7:0]};
      send(w, 8, 1'b1, 6'h3F);
      apb(1'b0, ST, 32'h0);
      check(32'(rdv[3:0]), 32'h9);
      apb(1'b0, DT, 32'h0);
      check(rdv, 32'h0);
      pop(w);
      rs = lfsr(rs);
      w = {24'h0, rs[7:0]};
      t = irq_cnt;
      fork
         send(w, 8, 1'b1, 6'h04);
         begin
            repeat (100) @(posedge clk);
            apb(1'b0, ST, 32'h0);
            check(32'(rdv[5]), 32'h0);
         end
      join
      check(irq_cnt, t + 1);
      apb(1'b0, ST, 32'h0);
      check(32'(rdv[5:0]), 32'h25);
      apb(1'b0, DT, 32'h0);
      check(rdv, w);
      apb(1'b1, CT, 32'h03);
      t = irq_cnt;
      send(w, 8, 1'b1, 6'h3F);
      check(irq_cnt, t);
      apb(1'b1, CT, 32'h00);
      apb(1'b1, CT, 32'h83);
      apb(1'b0, ST, 32'h0);
      check(32'(rdv[4:0]), 32'h0);
      // Break held past one segment, so a repeat must follow
      t = irq_cnt;
      lowc = 0;
      apb(1'b1, CT, 32'hC3);
      for (k = 0; k < 40 && tx !== 1'b0; k++) @(posedge clk);
      check(32'(k > 2 && k < 40), 32'h1);
      repeat (20 * BC) @(posedge clk);
      apb(1'b0, ST, 32'h0);
      check(32'(rdv[6]), 32'h1);
      apb(1'b1, CT, 32'h83);
      for (k = 0; k < 2000 && tx !== 1'b1; k++) @(posedge clk);
      check(32'(lowc >= 27 * BC - 3 && lowc <= 27 * BC + 3), 32'h1);
      g = lowc;
      repeat (BC) @(posedge clk);
      check(lowc, g);
      check(irq_cnt, t);
      give_verdict();
   end
endmodule : tb_uart_break_and_receiver
`default_nettype wire
